// ==== src/sfirc_defs.vh ====
// Constants for the status flag idle/ready controller.
`ifndef SFIRC_DEFS_VH
`define SFIRC_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SFIRC_OFS_STATUS 8'h00
`define SFIRC_OFS_FIFO 8'h04
`define SFIRC_OFS_CTRL 8'h08
`define SFIRC_OFS_IDLETIME 8'h0c
`define SFIRC_OFS_INTSTS 8'h10
`define SFIRC_OFS_INTMASK 8'h14
`define SFIRC_OFS_DROPCNT 8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SFIRC_STS_VALID_BIT 0
`define SFIRC_STS_CMDRDY_BIT 1
`define SFIRC_STS_AVAIL_BIT 2
`define SFIRC_STS_EXPECT_BIT 3
`define SFIRC_STS_GO_BIT 5
`define SFIRC_STS_RESEND_BIT 6
`define SFIRC_CTRL_HIDDEN_BIT 0
`define SFIRC_CTRL_EXPECT_BIT 1
`define SFIRC_INT_IDLE_BIT 0
`define SFIRC_INT_READY_BIT 1
`define SFIRC_INT_DROP_BIT 2
`define SFIRC_INT_TMO_BIT 3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SFIRC_CTRL_RST 2'h0
`define SFIRC_INTMASK_RST 4'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SFIRC_CLK_MHZ 250
`define SFIRC_TIMEOUT_B_US 2000
// The idle timeout is 2000 us at 250 MHz, sized to the idle counter width.
`define SFIRC_TIMEOUT_B_CYC 20'h7a120
`define SFIRC_SETTLE_CYC 4'h4
`define SFIRC_HIDDEN_DLY_CYC 20'h10

`endif

// ==== src/sfirc_axil_slave.v ====
// AXI4-Lite slave front end that turns bus transfers into strobes.
`timescale 1ns/10ps
module sfirc_axil_slave #(
	parameter AW = 8
) (
	input wire sys_clk,
	input wire rst_n,
	input wire [AW-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [AW-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output wire wrEn,
	output reg [AW-1:0] wrAddr,
	output reg [31:0] wrData,
	output reg [3:0] wrStrb,
	input wire wrErr,
	output wire rdEn,
	output wire [AW-1:0] rdAddr,
	input wire [31:0] rdData,
	input wire rdErr
);

reg awHeld;
reg wHeld;

// Each channel is held until the pair is complete, so order does not matter.
assign s_axi_awready = ~awHeld;
assign s_axi_wready = ~wHeld;
assign wrEn = awHeld & wHeld & ~s_axi_bvalid;
assign s_axi_arready = ~s_axi_rvalid;
assign rdEn = s_axi_arvalid & ~s_axi_rvalid;
assign rdAddr = s_axi_araddr;

// Write address and data capture, then one response per pair.
always @(posedge sys_clk) begin
	if (!rst_n) begin
		awHeld <= 1'b0;
		wHeld <= 1'b0;
		wrAddr <= {AW{1'b0}};
		wrData <= 32'h0;
		wrStrb <= 4'h0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= 2'h0;
	end else begin
		if (s_axi_awvalid && !awHeld) begin
			awHeld <= 1'b1;
			wrAddr <= s_axi_awaddr;
		end
		if (s_axi_wvalid && !wHeld) begin
			wHeld <= 1'b1;
			wrData <= s_axi_wdata;
			wrStrb <= s_axi_wstrb;
		end
		if (wrEn) begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wrErr ? 2'h2 : 2'h0;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
end

// Read data is sampled in the address cycle; one read at a time.
always @(posedge sys_clk) begin
	if (!rst_n) begin
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h0;
		s_axi_rresp <= 2'h0;
	end else if (rdEn) begin
		s_axi_rvalid <= 1'b1;
		s_axi_rdata <= rdData;
		s_axi_rresp <= rdErr ? 2'h2 : 2'h0;
	end else if (s_axi_rready) begin
		s_axi_rvalid <= 1'b0;
	end
end

endmodule

// ==== src/sfirc_status_ctrl.v ====
// Status flag controller for the Idle and Ready conditions of one context.
//
// Notes on behaviour
// RULE1: After any change of condition the flags settle for a few cycles before they count.
// RULE2: Software polls the status register until the flag it waits for reads set.
// RULE3: Flag values mean something only while the status-valid flag reads 1.
// RULE4: Transitions happen only with a context selected and no context change pending. The code still moves Ready to Idle when ctxSelected goes low.
// RULE5: Where Idle would be entered, the block may go on to Ready by the hidden move.
// RULE6: The hidden move to Ready need not show that Idle was ever occupied.
// RULE7: Once time spent in Idle reaches the timeout the block stays Idle on its own.
// RULE8: While time in Idle is below the timeout the hidden move to Ready is allowed.
// RULE9: In Idle without host action the three flags read 0 and Idle is kept.
// RULE10: In Ready the expect flag is a software chosen constant 0 or 1.
// RULE11: Software works whichever value the expect flag takes in Ready.
// RULE12: In Idle a write of command-ready 1 moves to Ready with data-available 0.
// RULE13: Data written to the FIFO port in Idle is discarded.
// RULE14: In Idle writes of resend-response or execute-go change nothing.
// RULE15: In Ready writes of resend-response or execute-go change nothing.
// RULE16: The idle counter restarts on each Idle entry and saturates at the timeout.
`timescale 1ns/10ps
`include "sfirc_defs.vh"
module sfirc_status_ctrl #(
	parameter AW = 8,
	parameter CNT_W = 20,
	parameter [CNT_W-1:0] IDLE_TIMEOUT_CYC = `SFIRC_TIMEOUT_B_CYC,
	parameter [CNT_W-1:0] HIDDEN_DLY_CYC = `SFIRC_HIDDEN_DLY_CYC,
	parameter DROP_W = 16
) (
	input wire sys_clk,
	input wire rst_n,
	input wire [AW-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [AW-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire ctxSelected,
	input wire ctxChange,
	output reg [7:0] fifoByte,
	output reg fifoByteValid,
	output wire irq
);

// ----------------------------------------------------------------
// Local constants
// ----------------------------------------------------------------
localparam ST_IDLE = 2'b01;
localparam ST_READY = 2'b10;
localparam [3:0] SETTLE_CYC = `SFIRC_SETTLE_CYC;

// ----------------------------------------------------------------
// Bus front end
// ----------------------------------------------------------------
wire wrEn;
wire [AW-1:0] wrAddr;
wire [31:0] wrData;
wire [3:0] wrStrb;
wire rdEn;
wire [AW-1:0] rdAddr;
reg [31:0] rdData;
reg wrErr;
reg rdErr;

sfirc_axil_slave #(
	.AW(AW)
) uBus (
	.sys_clk(sys_clk),
	.rst_n(rst_n),
	.s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata),
	.s_axi_wstrb(s_axi_wstrb),
	.s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.wrEn(wrEn),
	.wrAddr(wrAddr),
	.wrData(wrData),
	.wrStrb(wrStrb),
	.wrErr(wrErr),
	.rdEn(rdEn),
	.rdAddr(rdAddr),
	.rdData(rdData),
	.rdErr(rdErr)
);

// ----------------------------------------------------------------
// State and storage
// ----------------------------------------------------------------
reg [1:0] state_reg;
reg [1:0] state_next;
reg [CNT_W-1:0] idleCnt_reg;
reg [CNT_W-1:0] idleCnt_next;
reg [3:0] settle_reg;
reg [3:0] settle_next;
reg [1:0] ctrl_reg;
reg [3:0] intSts_reg;
reg [3:0] intSts_next;
reg [3:0] intMask_reg;
reg [DROP_W-1:0] dropCnt_reg;

// ----------------------------------------------------------------
// Write decode
// ----------------------------------------------------------------
wire lowLane = wrEn & wrStrb[0];
wire stsWr = lowLane & (wrAddr == `SFIRC_OFS_STATUS);
wire fifoWr = lowLane & (wrAddr == `SFIRC_OFS_FIFO);
wire ctrlWr = lowLane & (wrAddr == `SFIRC_OFS_CTRL);
wire intStsWr = lowLane & (wrAddr == `SFIRC_OFS_INTSTS);
wire intMaskWr = lowLane & (wrAddr == `SFIRC_OFS_INTMASK);
wire cmdReqWr = stsWr & wrData[`SFIRC_STS_CMDRDY_BIT];

// The context must be held steady for any move out of Idle.
wire ctxOk = ctxSelected & ~ctxChange; // RULE4
wire inIdle = state_reg[0];
wire inReady = state_reg[1];

// Idle time has reached or passed the timeout.
wire idleExpired = (idleCnt_reg >= IDLE_TIMEOUT_CYC); // RULE7

// The hidden move waits a short delay so software can observe Idle if
// it polls quickly, but never fires once the timeout has run out.
wire hiddenOk = ctrl_reg[`SFIRC_CTRL_HIDDEN_BIT] &
	(idleCnt_reg >= HIDDEN_DLY_CYC) & ~idleExpired; // RULE8

// FIFO data in Idle is unexpected and is thrown away.
wire fifoDrop = fifoWr & inIdle; // RULE13
wire fifoTake = fifoWr & inReady & ctxOk;

// ----------------------------------------------------------------
// Condition sequencing
// ----------------------------------------------------------------
// Execute-go and resend-response bits are not looked at here at all, so
// such writes leave both conditions and all flags untouched.
always @* begin
	state_next = state_reg;
	case (state_reg)
		ST_IDLE: begin
			if (ctxOk && cmdReqWr) begin
				state_next = ST_READY; // RULE12
			end else if (ctxOk && hiddenOk) begin
				state_next = ST_READY; // RULE5
			end else begin
				state_next = ST_IDLE; // RULE9 RULE14
			end
		end
		ST_READY: begin
			if (!ctxSelected) begin
				state_next = ST_IDLE;
			end else begin
				state_next = ST_READY; // RULE15
			end
		end
		default: begin
			state_next = ST_IDLE;
		end
	endcase
end

// ----------------------------------------------------------------
// Idle duration counter
// ----------------------------------------------------------------
// Saturating keeps the comparison honest however long Idle lasts.
always @* begin
	idleCnt_next = idleCnt_reg;
	if (state_next[0] && !inIdle) begin
		idleCnt_next = {CNT_W{1'b0}}; // RULE16
	end else if (inIdle && !idleExpired) begin
		idleCnt_next = idleCnt_reg + {{(CNT_W-1){1'b0}}, 1'b1}; // RULE16
	end
end

// ----------------------------------------------------------------
// Status valid settling
// ----------------------------------------------------------------
// Every change of condition is followed by a short window in which the
// valid flag is low, so a reader never trusts half-updated flags.
always @* begin
	settle_next = settle_reg;
	if (state_next != state_reg) begin
		settle_next = SETTLE_CYC; // RULE1
	end else if (settle_reg != 4'h0) begin
		settle_next = settle_reg - 4'h1;
	end
end

wire status_valid_flag = (settle_reg == 4'h0); // RULE3

// Flags follow the present condition; data-available is never set here.
// A hidden move shows Ready only after Idle has been reported, unless HIDDEN_DLY_CYC is below SETTLE_CYC.
wire cmdRdyFlag = inReady; // RULE6
wire availFlag = 1'b0; // RULE9
wire expectFlag = inReady & ctrl_reg[`SFIRC_CTRL_EXPECT_BIT]; // RULE10

// ----------------------------------------------------------------
// Interrupt status
// ----------------------------------------------------------------
wire evIdle = state_next[0] & ~inIdle;
wire evReady = state_next[1] & ~inReady;
wire evTmo = inIdle & ~idleExpired &
	(idleCnt_next >= IDLE_TIMEOUT_CYC);
wire [3:0] intEv = {evTmo, fifoDrop, evReady, evIdle};

// A new event in the clearing cycle survives the write of one.
always @* begin
	intSts_next = intSts_reg;
	if (intStsWr) begin
		intSts_next = intSts_next & ~wrData[3:0];
	end
	intSts_next = intSts_next | intEv;
end

assign irq = |(intSts_reg & intMask_reg);

// ----------------------------------------------------------------
// Registers
// ----------------------------------------------------------------
always @(posedge sys_clk) begin
	if (!rst_n) begin
		state_reg <= ST_IDLE;
		idleCnt_reg <= {CNT_W{1'b0}};
		settle_reg <= SETTLE_CYC;
		intSts_reg <= 4'h0;
	end else begin
		state_reg <= state_next;
		idleCnt_reg <= idleCnt_next;
		settle_reg <= settle_next;
		intSts_reg <= intSts_next;
	end
end

// Software configuration and the drop counter.
always @(posedge sys_clk) begin
	if (!rst_n) begin
		ctrl_reg <= `SFIRC_CTRL_RST;
		intMask_reg <= `SFIRC_INTMASK_RST;
		dropCnt_reg <= {DROP_W{1'b0}};
	end else begin
		if (ctrlWr) begin
			ctrl_reg <= wrData[1:0];
		end
		if (intMaskWr) begin
			intMask_reg <= wrData[3:0];
		end
		if (fifoDrop && (dropCnt_reg != {DROP_W{1'b1}})) begin
			dropCnt_reg <= dropCnt_reg + {{(DROP_W-1){1'b0}}, 1'b1}; // RULE13
		end
	end
end

// Accepted FIFO bytes go to the command path as a one-cycle strobe.
always @(posedge sys_clk) begin
	if (!rst_n) begin
		fifoByte <= 8'h00;
		fifoByteValid <= 1'b0;
	end else begin
		fifoByteValid <= fifoTake;
		if (fifoTake) begin
			fifoByte <= wrData[7:0];
		end
	end
end

// ----------------------------------------------------------------
// Address checks
// ----------------------------------------------------------------
always @* begin
	if (wrAddr == `SFIRC_OFS_STATUS) begin
		wrErr = 1'b0;
	end else if (wrAddr == `SFIRC_OFS_FIFO) begin
		wrErr = 1'b0;
	end else if (wrAddr == `SFIRC_OFS_CTRL) begin
		wrErr = 1'b0;
	end else if (wrAddr == `SFIRC_OFS_INTSTS) begin
		wrErr = 1'b0;
	end else if (wrAddr == `SFIRC_OFS_INTMASK) begin
		wrErr = 1'b0;
	end else begin
		wrErr = 1'b1;
	end
end

// ----------------------------------------------------------------
// Read mux
// ----------------------------------------------------------------
// The FIFO port reads zero: no response data exists in these conditions.
always @* begin
	rdData = 32'h0;
	rdErr = 1'b0;
	if (rdAddr == `SFIRC_OFS_STATUS) begin
		rdData[`SFIRC_STS_VALID_BIT] = status_valid_flag; // RULE3
		rdData[`SFIRC_STS_CMDRDY_BIT] = cmdRdyFlag;
		rdData[`SFIRC_STS_AVAIL_BIT] = availFlag;
		rdData[`SFIRC_STS_EXPECT_BIT] = expectFlag;
	end else if (rdAddr == `SFIRC_OFS_FIFO) begin
		rdData = 32'h0;
	end else if (rdAddr == `SFIRC_OFS_CTRL) begin
		rdData[1:0] = ctrl_reg;
	end else if (rdAddr == `SFIRC_OFS_IDLETIME) begin
		rdData[CNT_W-1:0] = idleCnt_reg;
	end else if (rdAddr == `SFIRC_OFS_INTSTS) begin
		rdData[3:0] = intSts_reg;
	end else if (rdAddr == `SFIRC_OFS_INTMASK) begin
		rdData[3:0] = intMask_reg;
	end else if (rdAddr == `SFIRC_OFS_DROPCNT) begin
		rdData[DROP_W-1:0] = dropCnt_reg;
	end else begin
		rdErr = 1'b1;
	end
end

// A read has no side effect; rdEn only marks the sampling cycle.
wire unusedRd = rdEn;

endmodule

// ==== tb/sfirc_status_ctrl_sva.sv ====
// Port-level assertions for the status flag controller.
`timescale 1ns/10ps
`include "sfirc_defs.vh"
module sfirc_status_ctrl_sva (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic fifoByteValid,
	input wire logic irq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	// Remembers whether the read under way targets the status register.
	logic statRd_reg;
	always @(posedge sys_clk) begin
		if (!rst_n) statRd_reg <= 1'h0;
		else if (s_axi_arvalid && s_axi_arready) statRd_reg <= (s_axi_araddr == `SFIRC_OFS_STATUS);
	end

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	property p_idle_flags;
		s_axi_rvalid && statRd_reg && s_axi_rdata[0] && !s_axi_rdata[1] |-> s_axi_rdata[3:2] == 2'h0;
	endproperty
	a_idle_flags: assert property (p_idle_flags) else $error("idle flags not clear");
	property p_avail_low;
		s_axi_rvalid && statRd_reg && s_axi_rdata[0] |-> !s_axi_rdata[2];
	endproperty
	a_avail_low: assert property (p_avail_low) else $error("data available raised");
	property p_fifo_pulse;
		fifoByteValid |=> !fifoByteValid;
	endproperty
	a_fifo_pulse: assert property (p_fifo_pulse) else $error("fifo strobe too long");
	property p_fifo_cause;
		fifoByteValid |-> s_axi_bvalid || $past(s_axi_bvalid);
	endproperty
	a_fifo_cause: assert property (p_fifo_cause) else $error("fifo strobe without write");
	property p_rd_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
	property p_rd_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_rd_block: assert property (p_rd_block) else $error("second read accepted");
	property p_wr_answer;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
	endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
	property p_wr_hold;
		s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
	endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("address taken twice");

	// Main scenarios reached.
	c_fifo: cover property (fifoByteValid);
	c_ready: cover property (s_axi_rvalid && statRd_reg && s_axi_rdata[1:0] == 2'h3);
	c_irq: cover property (irq);
endmodule

bind sfirc_status_ctrl sfirc_status_ctrl_sva u_sfirc_status_ctrl_sva (.sys_clk(sys_clk),
	.rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .fifoByteValid(fifoByteValid),
	.irq(irq));

// ==== tb/sfirc_status_ctrl_tb.sv ====
// Self-checking bench for the status flag controller.
`timescale 1ns/10ps
`include "sfirc_defs.vh"
module sfirc_status_ctrl_tb;
	localparam [7:0] STS = `SFIRC_OFS_STATUS;
	localparam [7:0] CTL = `SFIRC_OFS_CTRL;
	logic sys_clk = 1'h0, rst_n = 1'h0, ctxSelected = 1'h1, ctxChange = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, rdv;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [1:0] rsp;
	wire awRdy, wRdy, bValid, arRdy, rValid, irq, fifoByteValid;
	wire [1:0] bResp, rResp;
	wire [31:0] rData;
	wire [7:0] fifoByte;
	int nFail = 0, nCompared = 0, cycles = 0, pulses = 0;

	// Short timeout values keep the idle expiry inside a brief run.
	sfirc_status_ctrl #(.IDLE_TIMEOUT_CYC(20'h28), .HIDDEN_DLY_CYC(20'h4)) u_sfirc_status_ctrl (
		.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(awRdy), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(wRdy),
		.s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(arRdy),
		.s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
		.s_axi_rready(s_axi_rready), .ctxSelected(ctxSelected), .ctxChange(ctxChange),
		.fifoByte(fifoByte), .fifoByteValid(fifoByteValid), .irq(irq));

	always #2 sys_clk = ~sys_clk;

	// Strobes are counted at the falling edge, where they have settled.
	always @(negedge sys_clk) if (fifoByteValid === 1'h1) pulses++;

	// A hung handshake ends the run as a failure.
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			nFail++;
			finish_test;
		end
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		nCompared++;
		if (got !== exp) begin
			nFail++;
			$display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// Ready signals are looked at mid-cycle, so each release follows the edge that took it.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w, b;
		aw = 1'h0;
		w = 1'h0;
		b = 1'h0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (!b) begin
			@(negedge sys_clk);
			aw = s_axi_awvalid && awRdy;
			w = s_axi_wvalid && wRdy;
			b = bValid;
			rsp = bResp;
			@(posedge sys_clk);
			if (aw) s_axi_awvalid <= 1'h0;
			if (w) s_axi_wvalid <= 1'h0;
		end
		// Ready stays high between calls, so back-to-back calls never write it twice at one edge.
		chk({30'h0, rsp}, {30'h0, er});
	endtask

	task automatic rd(input logic [7:0] a);
		logic ar, r;
		r = 1'h0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		while (!r) begin
			@(negedge sys_clk);
			ar = s_axi_arvalid && arRdy;
			r = rValid;
			rdv = rData;
			rsp = rResp;
			@(posedge sys_clk);
			if (ar) s_axi_arvalid <= 1'h0;
		end
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		chk(rdv, exp);
		chk({30'h0, rsp}, 32'h0);
	endtask

	// Software keeps reading status until the valid flag is set; only the timeout ends it.
	task automatic poll(input logic [31:0] exp);
		rd(STS);
		while (rdv[0] !== 1'h1) rd(STS);
		chk(rdv, exp);
		chk({30'h0, rsp}, 32'h0);
	endtask

	// Writes the go and resend bits one at a time; neither may move the flags.
	task automatic noop(input logic [31:0] exp);
		for (int i = 5; i < 7; i++) begin
			wr(STS, 32'h1 << i, 2'h0);
			cyc(6);
			rdc(STS, exp);
		end
	endtask

	task automatic finish_test;
		if (nFail == 0 && nCompared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		cyc(12);
		rst_n <= 1'h1;
		rdc(STS, 32'h0);
		rdc(CTL, 32'h0);
		rdc(`SFIRC_OFS_INTMASK, 32'h0);
		cyc(4);
		rdc(STS, 32'h1);
		noop(32'h1);
		wr(`SFIRC_OFS_FIFO, 32'h5a, 2'h0);
		rdc(`SFIRC_OFS_DROPCNT, 32'h1);
		chk(pulses, 32'h0);
		chk({31'h0, irq}, 32'h0);
		wr(`SFIRC_OFS_INTMASK, 32'h4, 2'h0);
		chk({31'h0, irq}, 32'h1);
		wr(`SFIRC_OFS_INTSTS, 32'h4, 2'h0);
		chk({31'h0, irq}, 32'h0);
		rdc(`SFIRC_OFS_INTSTS, 32'h8);
		cyc(50);
		rdc(`SFIRC_OFS_IDLETIME, 32'h28);
		wr(CTL, 32'h1, 2'h0);
		cyc(20);
		rdc(STS, 32'h1);
		wr(STS, 32'h2, 2'h0);
		rd(STS);
		chk(rdv & 32'h1, 32'h0);
		poll(32'h3);
		noop(32'h3);
		wr(CTL, 32'h3, 2'h0);
		rdc(STS, 32'hb);
		wr(`SFIRC_OFS_FIFO, 32'ha5, 2'h0);
		cyc(2);
		chk({24'h0, fifoByte}, 32'ha5);
		chk(pulses, 32'h1);
		// A dropped context sends Ready back to Idle, and a context change keeps it there.
		ctxSelected <= 1'h0;
		cyc(10);
		rdc(STS, 32'h1);
		ctxSelected <= 1'h1;
		ctxChange <= 1'h1;
		wr(STS, 32'h2, 2'h0);
		cyc(6);
		rdc(STS, 32'h1);
		ctxChange <= 1'h0;
		cyc(10);
		rdc(STS, 32'hb);
		rdc(`SFIRC_OFS_INTSTS, 32'hb);
		wr(8'h1c, 32'h1, 2'h2);
		rd(8'h1c);
		chk(rdv, 32'h0);
		chk({30'h0, rsp}, 32'h2);
		finish_test;
	end
endmodule
